// File: logic/pttmr_counter.v
// 24-bit down counter with reload, clear and wrap detection
`timescale 1ns/1ps
module pttmr_counter #(
  parameter W = 24
) (
  input wire clk_sys,
  input wire reset,
  input wire enable,
  input wire halt,
  input wire clear,
  input wire [W-1:0] reload,
  output wire [W-1:0] value,
  output wire wrap
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  reg wrap_q;
  reg wrap_d;

  always @* begin
    cnt_d = cnt_q;
    wrap_d = 1'b0;
    if (clear) begin
      // a clearing write never counts as reaching zero
      cnt_d = {W{1'b0}};
    end else if (enable && !halt) begin
      if (cnt_q == {W{1'b0}}) begin
        cnt_d = reload;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
        wrap_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= {W{1'b0}};
      wrap_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wrap_q <= wrap_d;
    end
  end

  assign value = cnt_q;
  assign wrap = wrap_q;
endmodule

// File: logic/pttmr_regs.vh
// register map, field positions, reset values and timing for the tick timer
`ifndef PTTMR_REGS_VH
`define PTTMR_REGS_VH

`define PTTMR_OFS_CTRL 5'h00
`define PTTMR_OFS_RELOAD 5'h04
`define PTTMR_OFS_CURRENT 5'h08
`define PTTMR_OFS_IRQ_STAT 5'h0C
`define PTTMR_OFS_IRQ_MASK 5'h10

`define PTTMR_BIT_ENABLE 0
`define PTTMR_BIT_IRQ_EN 1
`define PTTMR_BIT_SRC_SEL 2
`define PTTMR_BIT_WRAP 16

`define PTTMR_CNT_W 24
`define PTTMR_CTRL_RESET 3'h4
`define PTTMR_RELOAD_RESET 24'h000000
`define PTTMR_IRQ_MASK_RESET 1'h0
`define PTTMR_SYNC_STAGES 2

`endif

// File: logic/pttmr_sync.v
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module pttmr_sync (
  input wire clk_sys,
  input wire reset,
  input wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// File: logic/pttmr_top.v
// tick timer top: wishbone slave, control, counter and interrupt logic
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pttmr_regs.vh"
module pttmr_top #(
  parameter CNT_W = `PTTMR_CNT_W
) (
  input wire clk_sys,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire debug_halt,
  output reg tick_pend_q,
  output reg irq_q
);

  ////////////////////////////////////////////////////////////////////////
  reg enable_q;
  reg irq_en_q;
  reg wrap_seen_flag_q;
  reg [CNT_W-1:0] reload_q;
  reg irq_stat_q;
  reg irq_mask_q;
  wire halt_sync;
  wire [CNT_W-1:0] cur_value;
  wire wrap_evt;

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;
  wire [4:0] adr = {wb_adr_i[4:2], 2'b00};
  wire hit_ctrl = (adr == `PTTMR_OFS_CTRL);
  wire hit_reload = (adr == `PTTMR_OFS_RELOAD);
  wire hit_cur = (adr == `PTTMR_OFS_CURRENT);
  wire hit_stat = (adr == `PTTMR_OFS_IRQ_STAT);
  wire hit_mask = (adr == `PTTMR_OFS_IRQ_MASK);

  // debug halt is a pin, synchronised first
  pttmr_sync u_halt_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(debug_halt),
    .dout(halt_sync)
  );

  // the clear does not raise a wrap event
  pttmr_counter #(
    .W(CNT_W)
  ) u_counter (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(enable_q),
    .halt(halt_sync),
    .clear(wr && hit_cur),
    .reload(reload_q),
    .value(cur_value),
    .wrap(wrap_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // control, reload and mask registers; byte lane 0 holds control bits
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b0;
      irq_en_q <= 1'b0;
      reload_q <= `PTTMR_RELOAD_RESET;
      irq_mask_q <= `PTTMR_IRQ_MASK_RESET;
    end else if (wr) begin
      if (hit_ctrl && wb_sel_i[0]) begin
        enable_q <= wb_dat_i[`PTTMR_BIT_ENABLE];
        irq_en_q <= wb_dat_i[`PTTMR_BIT_IRQ_EN];
      end
      if (hit_reload) begin
        if (wb_sel_i[0]) reload_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) reload_q[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) reload_q[23:16] <= wb_dat_i[23:16];
      end
      if (hit_mask && wb_sel_i[0]) begin
        irq_mask_q <= wb_dat_i[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wrap flag: set wins over read clear
  // a clearing write to current value also clears the flag
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrap_seen_flag_q <= 1'b0;
    end else if (wrap_evt) begin
      wrap_seen_flag_q <= 1'b1;
    end else if ((rd && hit_ctrl) || (wr && hit_cur)) begin
      wrap_seen_flag_q <= 1'b0;
    end
  end

  // pend pulse only with irq enable
  // wrap_evt comes only from one-to-zero steps
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_pend_q <= 1'b0;
    end else begin
      tick_pend_q <= wrap_evt && irq_en_q;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_stat_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (wrap_evt && irq_en_q) begin
        irq_stat_q <= 1'b1;
      end else if (wr && hit_stat && wb_sel_i[0] && wb_dat_i[0]) begin
        irq_stat_q <= 1'b0;
      end
      irq_q <= irq_stat_q && irq_mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single-cycle answer; unmapped words, calibration slot included, read 0
  // no calibration register
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        // source select reads 1: core clock only
        if (hit_ctrl) begin
          wb_dat_o <= {15'h0000, wrap_seen_flag_q, 13'h0000, 1'b1,
                       irq_en_q, enable_q};
        end
        if (hit_reload) begin
          wb_dat_o <= {8'h00, reload_q};
        end
        if (hit_cur) begin
          wb_dat_o <= {8'h00, cur_value};
        end
        if (hit_stat) begin
          wb_dat_o <= {31'h00000000, irq_stat_q};
        end
        if (hit_mask) begin
          wb_dat_o <= {31'h00000000, irq_mask_q};
        end
      end
    end
  end

endmodule

// File: test/pttmr_monitor.sv
// checker for the tick timer bus answers and event outputs
`timescale 1ns/1ps
module pttmr_monitor (
  input wire clk_sys,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire tick_pend_q,
  input wire irq_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd; wb_ack_o && !wb_we_i; endsequence
  sequence s_wr; wb_ack_o && wb_we_i; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data without ack");
  property p_src; s_rd ##0 wb_adr_i == 5'h00 |-> wb_dat_o[2]; endproperty
  a_src: assert property (p_src) else $error("source select low");
  property p_hi; s_rd ##0 (wb_adr_i == 5'h04 || wb_adr_i == 5'h08)
    |-> wb_dat_o[31:24] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("upper byte set");
  property p_pend; tick_pend_q |=> !tick_pend_q; endproperty
  a_pend: assert property (p_pend) else $error("pend too long");
  property p_rise;
    $rose(irq_q) |-> $past(tick_pend_q) || $past(wb_ack_o && wb_we_i);
  endproperty
  a_rise: assert property (p_rise) else $error("irq without cause");
  property p_fall; $fell(irq_q) |-> $past(wb_ack_o && wb_we_i); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule

bind pttmr_top pttmr_monitor u_mon (.clk_sys(clk_sys), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tick_pend_q(tick_pend_q), .irq_q(irq_q));

// File: test/pttmr_top_tb.sv
// self-checking bench for the tick timer
`timescale 1ns/1ps
module pttmr_top_tb;
  logic clk_sys = 0, reset = 1, cyc = 0, stb = 0, we = 0, halt = 0;
  logic [4:0] adr = 0;
  logic [31:0] wdat = 0, rdat, d0, d1;
  logic [3:0] sel = 4'hF;
  wire [31:0] dat_o;
  wire ack, pend, irq;
  integer seed = 30, num_errors = 0, num_checks = 0, cyc_n = 0;
  integer t_ack, t, n, k, n_pend = 0, gap = 0, last_gap = 0;
  pttmr_top dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .debug_halt(halt), .tick_pend_q(pend), .irq_q(irq));
  // one clock only: the counter clock is the core clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // edges between pend pulses give the wrap period
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    gap <= pend ? 1 : gap + 1;
    if (pend) begin
      n_pend <= n_pend + 1;
      last_gap <= gap;
    end
  end
  ////////////////////////////////////////
  task err(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task chk(input logic [31:0] g, e, input string m);
    num_checks++;
    if (g !== e) err(m);
  endtask
  // reload lanes 0..2 follow sel, the upper byte stays zero
  function automatic logic [31:0] exp_lanes(input logic [31:0] o, v,
      input logic [3:0] s);
    integer b;
    exp_lanes = 32'h00000000;
    for (b = 0; b < 3; b++)
      exp_lanes[8*b +: 8] = s[b] ? v[8*b +: 8] : o[8*b +: 8];
  endfunction
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    integer i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i == 50) err("bus timeout");
    rdat = dat_o;
    t_ack = cyc_n;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e, input string m);
    wb(0, a, 0);
    chk(rdat, e, m);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #40000;
    err("watchdog");
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    rd(5'h00, 32'h4, "ctrl after reset");
    wb(1, 5'h14, $random(seed));
    rd(5'h14, 0, "unmapped");
    d0 = $random(seed) | 32'hFF000000;
    wb(1, 5'h04, d0);
    rd(5'h04, {8'h00, d0[23:0]}, "reload");
    d1 = $random(seed);
    sel <= 4'h5;
    wb(1, 5'h04, d1);
    sel <= 4'hF;
    rd(5'h04, exp_lanes(d0, d1, 4'h5), "reload lanes");
    n = 2 + {$random(seed)} % 6;
    wb(1, 5'h04, n);
    wb(1, 5'h10, 1);
    wb(1, 5'h00, 3);
    repeat (40) @(posedge clk_sys);
    chk(last_gap, n + 1, "period");
    chk(irq, 1, "irq level");
    wb(1, 5'h00, 0);
    rd(5'h00, 32'h10004, "flag set");
    rd(5'h00, 32'h4, "flag read clear");
    wb(1, 5'h0C, 1);
    chk(irq, 0, "irq cleared");
    k = n_pend;
    wb(1, 5'h00, 1);
    repeat (30) @(posedge clk_sys);
    wb(1, 5'h00, 0);
    wb(1, 5'h08, $random(seed));
    chk(n_pend, k, "pend without irq enable");
    rd(5'h00, 32'h4, "flag after clear");
    wb(1, 5'h04, 32'h00000FFF);
    wb(1, 5'h00, 1);
    wb(1, 5'h08, $random(seed));
    wb(0, 5'h08, 0);
    t = t_ack;
    d0 = rdat;
    wb(0, 5'h08, 0);
    chk(d0[31:12], 0, "current range");
    chk(d0 - rdat, t_ack - t, "decrement");
    halt <= 1;
    repeat (4) @(posedge clk_sys);
    wb(0, 5'h08, 0);
    d0 = rdat;
    repeat (9) @(posedge clk_sys);
    rd(5'h08, d0, "halt hold");
    halt <= 0;
    wb(1, 5'h00, 0);
    sel <= 4'h0;
    wb(1, 5'h08, 32'hFFFFFFFF);
    sel <= 4'hF;
    rd(5'h08, 0, "current cleared");
    k = n_pend;
    wb(1, 5'h04, 0);
    wb(1, 5'h00, 3);
    repeat (20) @(posedge clk_sys);
    chk(n_pend, k, "zero reload pend");
    rd(5'h00, 32'h7, "zero reload flag");
    wb(1, 5'h10, 0);
    wb(1, 5'h04, n);
    repeat (20) @(posedge clk_sys);
    rd(5'h0C, 1, "status sticky");
    chk(irq, 0, "irq masked");
    wb(1, 5'h10, 1);
    chk(irq, 1, "irq unmasked");
    end_of_test;
  end
endmodule
